//--- drive_input_checker.sv
// assertions on the ports of the drive command input decoder
// assumes it is bound to drive_input_cmd and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module drive_input_checker #(
    parameter FAST_CYC = 100000
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic comm_shutoff_in,
    input wire logic ramp_done,
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] rd_data_q,
    input wire logic gate_on_q,
    input wire logic ramp_down_q,
    input wire logic coast_q,
    input wire logic vf_mode_q,
    input wire logic [1:0] speed_src_q,
    input wire logic [3:0] speed_step_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] sel_q;
    logic comm_q;
    int cnt_q;
    wire sel_wr = wr_en && addr == 8'h00;
    // comm level alone decides a shutoff for selections 0, 2 and 4; any other selection always shuts off
    wire barred = (sel_q == 16'h0000 && comm_q) || (sel_q == 16'h0002 && !comm_q)
        || (sel_q == 16'h0004 && comm_q) || !(sel_q inside {16'h0000, 16'h0002, 16'h0004});
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_q <= 16'h0000;
            comm_q <= 1'b0;
            cnt_q <= 0;
        end
        else
        begin
            comm_q <= comm_shutoff_in;
            if (sel_wr)
                sel_q <= wr_data;
            if (sel_wr || comm_q != comm_shutoff_in)
                cnt_q <= 0;
            else if (cnt_q < FAST_CYC + 8)
                cnt_q <= cnt_q + 1;
        end
    end
    sequence decel_end;
        ramp_down_q && ramp_done;
    endsequence
    sequence shut_settled;
        cnt_q == FAST_CYC + 8 && barred;
    endsequence
    coast_off_a: assert property (coast_q |-> !gate_on_q && !ramp_down_q)
        else $error("coast flag while output driven");
    decel_gate_a: assert property (ramp_down_q |-> gate_on_q)
        else $error("deceleration without output");
    decel_stop_a: assert property (decel_end |=> !gate_on_q && !ramp_down_q)
        else $error("ramp end did not stop output");
    gate_fall_a: assert property ($fell(gate_on_q) |-> coast_q || $past(ramp_down_q))
        else $error("output dropped without coast or ramp");
    vf_idle_a: assert property ($changed(vf_mode_q) |-> !$past(gate_on_q))
        else $error("control method changed while running");
    shut_contact_a: assert property (shut_settled |-> !gate_on_q)
        else $error("output on under shutoff contact state");
    speed_prio_a: assert property (speed_src_q != 2'h1 |->
        (speed_src_q == 2'h2) == (speed_step_q != 4'h0))
        else $error("speed source priority wrong");
    read_gap_a: assert property (!$past(rd_en) |-> rd_data_q == 16'h0000)
        else $error("read data outside its cycle");
endmodule
bind drive_input_cmd drive_input_checker #(.FAST_CYC(FAST_CYC)) checker_i (
    .ref_clk, .rst_n, .comm_shutoff_in, .ramp_done, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data_q, .gate_on_q, .ramp_down_q, .coast_q, .vf_mode_q, .speed_src_q, .speed_step_q);
`default_nettype wire

//--- drive_input_cmd.v
// drive command input decoder: terminal functions, shutoff, start/stop decode
// assumes inputs synchronous-safe via local synchronisers, one 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "drive_input_consts.vh"

module drive_input_cmd #(
    parameter NTERM = 5,
    parameter FAST_CYC = `RESP_FAST_CYC,
    parameter SLOW_CYC = `RESP_SLOW_CYC,
    parameter SEC_CYC = `CLK_HZ
)(
    input wire ref_clk,
    input wire rst_n,
    input wire [NTERM-1:0] term_in,
    input wire comm_shutoff_in,
    input wire ramp_done,
    input wire [7:0] addr,
    input wire [15:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [15:0] rd_data_q,
    output reg gate_on_q,
    output reg ramp_down_q,
    output reg coast_q,
    output reg reverse_q,
    output reg second_set_q,
    output reg vf_mode_q,
    output reg current_in_q,
    output reg [1:0] speed_src_q,
    output reg [3:0] speed_step_q
);
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_DECEL = 2'd2;
    localparam SRC_ANALOG = 2'd0;
    localparam SRC_JOG = 2'd1;
    localparam SRC_MULTI = 2'd2;
    localparam SRC_PID = 2'd3;
    localparam integer FAST_HOLD_N = FAST_CYC - `PIPE_CYC;
    localparam integer SLOW_HOLD_N = SLOW_CYC - `PIPE_CYC;
    localparam [23:0] FAST_HOLD = FAST_HOLD_N[23:0];
    localparam [23:0] SLOW_HOLD = SLOW_HOLD_N[23:0];
    localparam [31:0] SEC_LAST = SEC_CYC - 1;

    reg [15:0] shut_sel_q;
    reg [15:0] stop_sel_q;
    reg [15:0] mode_q;
    reg [15:0] fsel_q [0:NTERM-1];
    reg [1:0] state_q;
    reg latch_run_q;
    reg latch_rev_q;
    reg fwd_prev_q;
    reg rev_prev_q;
    reg [31:0] cyc_cnt_q;
    reg [6:0] sec_cnt_q;
    integer k;

    wire [NTERM:0] raw = {comm_shutoff_in, term_in};
    wire [NTERM:0] fast;
    wire [NTERM:0] filt;
    wire [NTERM-1:0] h_low, h_mid, h_high, h_rt, h_cur, h_jog, h_s15;
    wire [NTERM-1:0] h_ren, h_il, h_pid, h_vf, h_shut, h_stop, h_fwd, h_rev;
    wire [NTERM-1:0] a_ren, a_il, a_stop;

    function [15:0] fn_reset;
        input integer idx;
        begin
            case (idx)
                0: fn_reset = `RST_FN_T0;
                1: fn_reset = `RST_FN_T1;
                2: fn_reset = `RST_FN_T2;
                3: fn_reset = `RST_FN_T3;
                default: fn_reset = `RST_FN_T4;
            endcase
        end
    endfunction

    assign fast[NTERM] = 1'b1;

    genvar i;
    generate
        for (i = 0; i <= NTERM; i = i + 1)
        begin : g_in
            reg s1_q, s2_q, f_q;
            reg [23:0] cnt_q;
            // two-stage synchroniser then stability filter
            always @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    f_q <= 1'b0;
                    cnt_q <= 24'h000000;
                end
                else
                begin
                    s1_q <= raw[i];
                    s2_q <= s1_q;
                    if (s2_q == f_q)
                        cnt_q <= 24'h000000;
                    else if (cnt_q >= (fast[i] ? FAST_HOLD : SLOW_HOLD))
                    begin
                        f_q <= s2_q;
                        cnt_q <= 24'h000000;
                    end
                    else
                        cnt_q <= cnt_q + 24'h000001;
                end
            end
            assign filt[i] = f_q;
        end
        for (i = 0; i < NTERM; i = i + 1)
        begin : g_fn
            wire [15:0] f = fsel_q[i];
            wire on = filt[i];
            assign fast[i] = (f == `FN_RUN_EN) || (f == `FN_SHUTOFF);
            assign h_low[i] = on && (f == `FN_LOW);
            assign h_mid[i] = on && (f == `FN_MID);
            assign h_high[i] = on && (f == `FN_HIGH);
            assign h_rt[i] = on && (f == `FN_SECOND);
            assign h_cur[i] = on && (f == `FN_CURRENT);
            assign h_jog[i] = on && (f == `FN_JOG);
            assign h_s15[i] = on && (f == `FN_SPEED15);
            assign h_ren[i] = on && (f == `FN_RUN_EN);
            assign h_il[i] = on && (f == `FN_INTERLOCK);
            assign h_pid[i] = on && (f == `FN_PID);
            assign h_vf[i] = on && (f == `FN_VF);
            assign h_shut[i] = on && (f == `FN_SHUTOFF);
            assign h_stop[i] = on && (f == `FN_STOP_HOLD);
            assign h_fwd[i] = on && (f == `FN_FWD);
            assign h_rev[i] = on && (f == `FN_REV);
            assign a_ren[i] = (f == `FN_RUN_EN);
            assign a_il[i] = (f == `FN_INTERLOCK);
            assign a_stop[i] = (f == `FN_STOP_HOLD);
        end
    endgenerate

    // merged functions
    wire jog = |h_jog;
    wire multi = |{h_low, h_mid, h_high, h_s15};
    wire pid = |h_pid;
    wire rt = |h_rt;
    wire vf = |h_vf;
    wire fwd = |h_fwd;
    wire rev = |h_rev;
    wire ext_off = |h_shut;
    wire comm_off = filt[NTERM];
    wire stop_on = |h_stop;
    wire stop_asg = |a_stop;

    // contact logic for the two shutoff sources
    reg op_ok;
    always @*
    begin
        if (shut_sel_q == `SHUT_SEL_NC)
            op_ok = ext_off && comm_off;
        else if (shut_sel_q == `SHUT_SEL_MIX)
            op_ok = ext_off && !comm_off;
        else if (shut_sel_q == `SHUT_SEL_NO)
            op_ok = !ext_off && !comm_off;
        else
            op_ok = 1'b0;
    end
    wire shutoff = !op_ok;
    // a missing run-enable, or a missing interlock in interlock mode, inhibits besides shutoff
    wire ren_block = (|a_ren) && !(|h_ren);
    wire il_block = (mode_q == `MODE_INTERLOCK) && (|a_il) && !(|h_il);
    wire inhibit = shutoff || ren_block || il_block;

    // stop method decode
    wire sm_coast = (stop_sel_q <= `SM_COAST_MAX);
    wire sm_dir_rng = (stop_sel_q >= `SM_DIR_MIN) && (stop_sel_q <= `SM_DIR_MAX);
    wire start_dir = sm_dir_rng || (stop_sel_q == `SM_DIR_DECEL);
    wire coast_en = sm_coast || sm_dir_rng;
    wire [15:0] sm_less = stop_sel_q - `SM_DIR_OFS;
    wire [6:0] coast_sec = sm_coast ? stop_sel_q[6:0] : sm_less[6:0];
    wire hold_mode = stop_asg && !jog;

    reg start_req;
    reg dir_rev;
    always @*
    begin
        if (hold_mode)
        begin
            start_req = latch_run_q;
            dir_rev = latch_rev_q;
        end
        else if (start_dir)
        begin
            start_req = fwd;
            dir_rev = rev;
        end
        else
        begin
            start_req = fwd ^ rev;
            dir_rev = rev;
        end
    end

    wire sec_tick = (cyc_cnt_q == SEC_LAST);
    wire coast_due = coast_en && (sec_cnt_q >= coast_sec);

    // three-wire self-hold latch
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latch_run_q <= 1'b0;
            latch_rev_q <= 1'b0;
            fwd_prev_q <= 1'b0;
            rev_prev_q <= 1'b0;
        end
        else
        begin
            fwd_prev_q <= fwd;
            rev_prev_q <= rev;
            // shutoff deliberately leaves the latch alone
            if (hold_mode && !stop_on)
                latch_run_q <= 1'b0;
            else if (hold_mode && fwd && !fwd_prev_q)
            begin
                latch_run_q <= 1'b1;
                latch_rev_q <= 1'b0;
            end
            else if (hold_mode && rev && !rev_prev_q)
            begin
                latch_run_q <= 1'b1;
                latch_rev_q <= 1'b1;
            end
        end
    end

    // run state machine
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            gate_on_q <= 1'b0;
            ramp_down_q <= 1'b0;
            coast_q <= 1'b0;
            reverse_q <= 1'b0;
            cyc_cnt_q <= 32'h00000000;
            sec_cnt_q <= 7'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start_req && !inhibit)
                    begin
                        state_q <= ST_RUN;
                        gate_on_q <= 1'b1;
                        coast_q <= 1'b0;
                        reverse_q <= dir_rev;
                    end
                end
                ST_RUN:
                begin
                    if (inhibit)
                    begin
                        state_q <= ST_IDLE;
                        gate_on_q <= 1'b0;
                        coast_q <= 1'b1;
                    end
                    else if (!start_req)
                    begin
                        state_q <= ST_DECEL;
                        ramp_down_q <= 1'b1;
                        cyc_cnt_q <= 32'h00000000;
                        sec_cnt_q <= 7'h00;
                    end
                    else
                        reverse_q <= dir_rev;
                end
                ST_DECEL:
                begin
                    if (inhibit || coast_due)
                    begin
                        state_q <= ST_IDLE;
                        gate_on_q <= 1'b0;
                        ramp_down_q <= 1'b0;
                        coast_q <= 1'b1;
                    end
                    else if (start_req)
                    begin
                        state_q <= ST_RUN;
                        ramp_down_q <= 1'b0;
                        reverse_q <= dir_rev;
                    end
                    else if (ramp_done)
                    begin
                        state_q <= ST_IDLE;
                        gate_on_q <= 1'b0;
                        ramp_down_q <= 1'b0;
                    end
                    else
                    begin
                        cyc_cnt_q <= sec_tick ? 32'h00000000 : cyc_cnt_q + 32'h00000001;
                        if (sec_tick && sec_cnt_q != 7'h7f)
                            sec_cnt_q <= sec_cnt_q + 7'h01;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    gate_on_q <= 1'b0;
                    ramp_down_q <= 1'b0;
                end
            endcase
        end
    end

    // speed source, parameter set and analog input selection
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            speed_src_q <= SRC_ANALOG;
            speed_step_q <= 4'h0;
            second_set_q <= 1'b0;
            vf_mode_q <= 1'b0;
            current_in_q <= 1'b0;
        end
        else
        begin
            if (jog)
                speed_src_q <= SRC_JOG;
            else if (multi)
                speed_src_q <= SRC_MULTI;
            else if (pid)
                speed_src_q <= SRC_PID;
            else
                speed_src_q <= SRC_ANALOG;
            speed_step_q <= {|h_s15, |h_high, |h_mid, |h_low};
            second_set_q <= rt || vf;
            if (state_q == ST_IDLE)
                vf_mode_q <= vf;
            current_in_q <= |h_cur;
        end
    end

    // register port
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shut_sel_q <= `RST_SHUTOFF_SEL;
            stop_sel_q <= `RST_STOP_METHOD;
            mode_q <= `RST_OP_MODE;
            for (k = 0; k < NTERM; k = k + 1)
                fsel_q[k] <= fn_reset(k);
            rd_data_q <= 16'h0000;
        end
        else
        begin
            if (wr_en)
            begin
                if (addr == `OFS_SHUTOFF_SEL)
                    shut_sel_q <= wr_data;
                else if (addr == `OFS_STOP_METHOD)
                    stop_sel_q <= wr_data;
                else if (addr == `OFS_OP_MODE)
                    mode_q <= wr_data;
                for (k = 0; k < NTERM; k = k + 1)
                    if (addr == `OFS_TERM_FN0 + 8'h04 * k[7:0]
                        && !(wr_data == `FN_FWD && k != 0)
                        && !(wr_data == `FN_REV && k != 1))
                        fsel_q[k] <= wr_data;
            end
            rd_data_q <= 16'h0000;
            if (rd_en)
            begin
                if (addr == `OFS_SHUTOFF_SEL)
                    rd_data_q <= shut_sel_q;
                else if (addr == `OFS_STOP_METHOD)
                    rd_data_q <= stop_sel_q;
                else if (addr == `OFS_OP_MODE)
                    rd_data_q <= mode_q;
                else if (addr == `OFS_STATUS)
                begin
                    rd_data_q[`ST_BIT_GATE] <= gate_on_q;
                    rd_data_q[`ST_BIT_DECEL] <= ramp_down_q;
                    rd_data_q[`ST_BIT_COAST] <= coast_q;
                    rd_data_q[`ST_BIT_REV] <= reverse_q;
                    rd_data_q[`ST_BIT_SECOND] <= second_set_q;
                    rd_data_q[`ST_BIT_VF] <= vf_mode_q;
                    rd_data_q[`ST_BIT_SHUT] <= shutoff;
                    rd_data_q[`ST_BIT_LATCH] <= latch_run_q;
                    rd_data_q[`ST_LSB_FILT+NTERM:`ST_LSB_FILT] <= filt;
                    rd_data_q[`ST_LSB_SRC+1:`ST_LSB_SRC] <= speed_src_q;
                end
                else
                    for (k = 0; k < NTERM; k = k + 1)
                        if (addr == `OFS_TERM_FN0 + 8'h04 * k[7:0])
                            rd_data_q <= fsel_q[k];
            end
        end
    end
endmodule
`default_nettype wire

//--- drive_input_cmd_tb.sv
// self-checking bench for the drive command input decoder
// assumes field_switches drives the terminals and a 50 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module drive_input_cmd_tb;
    localparam FAST = 16;
    localparam SLOW = 40;
    localparam SEC = 20;
    localparam logic [12:0] gt = 13'h1000, rmp = 13'h0800, cst = 13'h0400, rev = 13'h0200;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ramp_done = 1'b0;
    logic bounce = 1'b0;
    logic [5:0] want = 6'h00;
    logic [7:0] addr = 8'h00;
    logic [15:0] wr_data = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic snap = 1'b0;
    logic pend_rd = 1'b0;
    wire logic [4:0] term_in;
    wire logic comm_shutoff_in, gate_on_q, ramp_down_q, coast_q, reverse_q;
    wire logic second_set_q, vf_mode_q, current_in_q;
    wire logic [15:0] rd_data_q;
    wire logic [1:0] speed_src_q;
    wire logic [3:0] speed_step_q;
    wire logic [12:0] pv = {gate_on_q, ramp_down_q, coast_q, reverse_q, second_set_q,
        vf_mode_q, current_in_q, speed_src_q, speed_step_q};
    logic [31:0] qr[$];
    logic [25:0] qp[$];
    int errors = 0;
    int compares = 0;
    logic [15:0] rst_tab[8] = '{16'h0000, 16'h270f, 16'h0000, 16'h003c,
        16'h003d, 16'h0000, 16'h0001, 16'h0002};
    // terminal functions for t2..t4, their levels, port mask and expected ports
    logic [59:0] fn_tab[7] = '{60'h03_03_04_1_0140_0100, 60'h03_03_04_2_0140_0100,
        60'h03_03_04_4_0140_0040, 60'h05_00_0e_7_003f_0011, 60'h05_00_0e_6_003f_0021,
        60'h05_00_0e_4_003f_0030, 60'h12_00_00_1_0180_0180};
    always #10 ref_clk = ~ref_clk;
    field_switches sw (.ref_clk(ref_clk), .want(want), .bounce(bounce),
        .term_in(term_in), .comm_shutoff_in(comm_shutoff_in));
    drive_input_cmd #(.FAST_CYC(FAST), .SLOW_CYC(SLOW), .SEC_CYC(SEC)) uut (
        .ref_clk, .rst_n, .term_in, .comm_shutoff_in, .ramp_done, .addr, .wr_data, .wr_en,
        .rd_en, .rd_data_q, .gate_on_q, .ramp_down_q, .coast_q, .reverse_q, .second_set_q,
        .vf_mode_q, .current_in_q, .speed_src_q, .speed_step_q);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        tick(1);
        wr_en <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        qr.push_back({m, e});
        addr <= a;
        rd_en <= 1'b1;
        tick(1);
        rd_en <= 1'b0;
        tick(1);
    endtask
    // wait n cycles, then note the expected ports and let the monitor sample them
    task automatic see(input int n, input logic [12:0] m, input logic [12:0] e);
        tick(n);
        qp.push_back({m, e});
        snap <= 1'b1;
        tick(1);
        snap <= 1'b0;
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        want <= 6'h00;
        ramp_done <= 1'b0;
        bounce <= 1'($urandom);
        tick(20);
        rst_n <= 1'b1;
        tick(1);
    endtask
    task automatic results;
        $display("compares %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        logic [31:0] r;
        logic [25:0] p;
        if (pend_rd)
        begin
            r = qr.pop_front();
            check(rd_data_q & r[31:16], r[15:0]);
        end
        if (snap)
        begin
            p = qp.pop_front();
            check({3'h0, pv & p[25:13]}, {3'h0, p[12:0]});
        end
        pend_rd = rd_en;
    end
    initial
    begin
        tick(30000);
        errors++;
        $display("unexpected at %0t: run did not finish", $time);
        results();
    end
    initial
    begin
        logic [15:0] rnd;
        logic [59:0] e;
        void'($urandom(62349));
        do_reset();
        foreach (rst_tab[i]) rd(8'(4 * i), 16'hffff, rst_tab[i]);
        rd(8'h20, 16'h00ff, 16'h0000);
        rd(8'h40, 16'hffff, 16'h0000);
        wr(8'h10, 16'h003c);
        rd(8'h10, 16'hffff, 16'h003d);
        wr(8'h0c, 16'h003d);
        rd(8'h0c, 16'hffff, 16'h003c);
        rnd = 16'($urandom);
        wr(8'h04, rnd);
        rd(8'h04, 16'hffff, rnd);
        $display("register test done");
        do_reset();
        want <= 6'h01;
        see(SLOW + 8, gt | rev, gt);
        want <= 6'h03;
        see(SLOW + 8, gt | rmp, gt | rmp);
        ramp_done <= 1'b1;
        see(4, gt | rmp, 13'h0000);
        ramp_done <= 1'b0;
        want <= 6'h02;
        see(SLOW + 8, gt | rev, gt | rev);
        $display("two-wire test done");
        for (int s = 0; s < 3; s++)
            for (int k = 0; k < 4; k++)
            begin
                do_reset();
                wr(8'h14, 16'h0018);
                wr(8'h00, 16'(2 * s));
                want <= {k[1], 2'h0, k[0], 2'h0};
                tick(FAST + 8);
                want[0] <= 1'b1;
                see(SLOW + 8, gt, (s == 0 ? k == 0 : s == 1 ? k == 3 : k == 1) ? gt : 13'h0);
            end
        $display("shutoff contact test done");
        do_reset();
        wr(8'h1c, 16'h0019);
        wr(8'h14, 16'h0018);
        want <= 6'h10;
        tick(SLOW + 8);
        want <= 6'h11;
        tick(SLOW + 8);
        want <= 6'h10;
        see(SLOW + 8, gt | rev, gt);
        want <= 6'h14;
        see(FAST + 8, gt | cst | rmp, cst);
        want <= 6'h10;
        tick(FAST + 8);
        rd(8'h20, 16'h0080, 16'h0080);
        want <= 6'h12;
        tick(SLOW + 8);
        want <= 6'h10;
        see(SLOW + 8, gt | rev, gt | rev);
        want <= 6'h00;
        see(SLOW + 8, gt | rmp, gt | rmp);
        $display("three-wire test done");
        foreach (fn_tab[i])
        begin
            e = fn_tab[i];
            do_reset();
            wr(8'h14, {8'h00, e[59:52]});
            wr(8'h18, {8'h00, e[51:44]});
            wr(8'h1c, {8'h00, e[43:36]});
            want <= {1'b0, e[34:32], 2'h0};
            see(SLOW + 8, e[28:16], e[12:0]);
        end
        $display("function test done");
        do_reset();
        wr(8'h18, 16'h000a);
        want <= 6'h01;
        see(SLOW + 8, gt, 13'h0000);
        want <= 6'h09;
        see(FAST + 8, gt, gt);
        wr(8'h08, 16'h0007);
        wr(8'h1c, 16'h000c);
        see(4, gt | cst, cst);
        want <= 6'h19;
        see(SLOW + 8, gt, gt);
        do_reset();
        wr(8'h1c, 16'h0019);
        wr(8'h14, 16'h0005);
        want <= 6'h15;
        tick(SLOW + 8);
        want <= 6'h14;
        see(SLOW + 8, gt | rmp, gt | rmp);
        $display("run enable and jog test done");
        do_reset();
        wr(8'h04, 16'h0000);
        want <= 6'h01;
        tick(SLOW + 8);
        want <= 6'h00;
        see(SLOW + 8, gt | rmp | cst, cst);
        wr(8'h04, 16'h03e9);
        want <= 6'h03;
        see(SLOW + 8, gt | rev, gt | rev);
        want <= 6'h02;
        for (int i = 0; i < 300 && ramp_down_q !== 1'b1; i++)
            tick(1);
        see(SEC / 2, gt | rmp | cst, gt | rmp);
        see(SEC, gt | rmp | cst, cst);
        wr(8'h04, 16'h22b8);
        want <= 6'h03;
        see(SLOW + 8, gt | rev, gt | rev);
        want <= 6'h02;
        see(SLOW + 3 * SEC, gt | rmp | cst, gt | rmp);
        $display("stop method test done");
        tick(4);
        results();
    end
endmodule
`default_nettype wire

//--- drive_input_consts.vh
// constants for the drive command input decoder
// assumes a 50 MHz core clock and the 16-bit register port of the decoder
`ifndef DRIVE_INPUT_CONSTS_VH
`define DRIVE_INPUT_CONSTS_VH

`define OFS_SHUTOFF_SEL 8'h00
`define OFS_STOP_METHOD 8'h04
`define OFS_OP_MODE 8'h08
`define OFS_TERM_FN0 8'h0c
`define OFS_STATUS 8'h20

`define RST_SHUTOFF_SEL 16'h0000
`define RST_STOP_METHOD 16'h270f
`define RST_OP_MODE 16'h0000
`define RST_FN_T0 16'h003c
`define RST_FN_T1 16'h003d
`define RST_FN_T2 16'h0000
`define RST_FN_T3 16'h0001
`define RST_FN_T4 16'h0002

`define FN_LOW 16'h0000
`define FN_MID 16'h0001
`define FN_HIGH 16'h0002
`define FN_SECOND 16'h0003
`define FN_CURRENT 16'h0004
`define FN_JOG 16'h0005
`define FN_SPEED15 16'h0008
`define FN_RUN_EN 16'h000a
`define FN_INTERLOCK 16'h000c
`define FN_PID 16'h000e
`define FN_VF 16'h0012
`define FN_SHUTOFF 16'h0018
`define FN_STOP_HOLD 16'h0019
`define FN_FWD 16'h003c
`define FN_REV 16'h003d

`define MODE_INTERLOCK 16'h0007
`define SHUT_SEL_NO 16'h0000
`define SHUT_SEL_NC 16'h0002
`define SHUT_SEL_MIX 16'h0004

`define SM_COAST_MAX 16'h0064
`define SM_DIR_MIN 16'h03e8
`define SM_DIR_MAX 16'h044c
`define SM_DIR_OFS 16'h03e8
`define SM_DIR_DECEL 16'h22b8

`define CLK_HZ 50000000
`define RESP_FAST_US 2000
`define RESP_SLOW_US 20000
`define PIPE_CYC 4
`define RESP_FAST_CYC (`RESP_FAST_US * (`CLK_HZ / 1000000))
`define RESP_SLOW_CYC (`RESP_SLOW_US * (`CLK_HZ / 1000000))

`define ST_BIT_GATE 0
`define ST_BIT_DECEL 1
`define ST_BIT_COAST 2
`define ST_BIT_REV 3
`define ST_BIT_SECOND 4
`define ST_BIT_VF 5
`define ST_BIT_SHUT 6
`define ST_BIT_LATCH 7
`define ST_LSB_FILT 8
`define ST_LSB_SRC 14

`endif

//--- field_switches.sv
// field contacts on the command terminals and the communication shutoff
// assumes the bench sets the wanted levels right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module field_switches (
    input wire logic ref_clk,
    input wire logic [5:0] want,
    input wire logic bounce,
    output logic [4:0] term_in,
    output logic comm_shutoff_in
);
    logic [5:0] now_q = 6'h00;
    logic [5:0] old_q = 6'h00;
    logic [2:0] cnt_q = 3'h0;
    // with bounce set, contacts chatter for a few cycles after each change, shorter than any hold
    always @(posedge ref_clk)
    begin
        if (want != now_q)
        begin
            old_q <= now_q;
            now_q <= want;
            cnt_q <= bounce ? 3'h4 : 3'h0;
        end
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
    end
    // operator start pulses and the stop contact reach the block here
    assign {comm_shutoff_in, term_in} = cnt_q[0] ? old_q : now_q;
endmodule
`default_nettype wire
